// *** core/tcl_top.sv ***
`timescale 1ns/10ps
`include "tcl_defines.svh"
module tcl_top #(
    parameter int unsigned BASE_CONV_CYC = `TCL_TC9_US * `TCL_CLK_MHZ,
    parameter int unsigned SHORT_CNV_CYC = `TCL_CNV_SHORT_US * `TCL_CLK_MHZ,
    parameter int CW = 27,
    parameter int LW = 24
) (
    input wire logic core_clk, // System clock, 100 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic bus_enable_pin, // Serial session enable, high opens
    input wire logic shared_clock_convert_pin, // Serial clock or convert control
    input wire logic dq_pin_in, // Data pin level
    output logic dq_pin_out, // Data pin drive value
    output logic dq_pin_oe, // Data pin drive enable
    input wire logic [11:0] sensor_code, // Converter result at conversion end
    output logic over_trip_output, // High at or above upper level
    output logic under_trip_output, // High at or below lower level
    output logic hysteresis_output // Thermostat with hysteresis
);
    tcl_ser_if sif ();

    logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
    logic sclk_prev_q, sel_prev_q;
    tcl_pkg::tcl_conv_state_t state_q;
    tcl_pkg::tcl_temp_t meas_q, th_q, tl_q;
    logic [3:0] cfg_nv_q;
    logic over_flag_q, under_flag_q;
    logic cont_q, sa_owner_q;
    logic [LW-1:0] low_cnt_q;
    logic over_q, under_q, hyst_q;
    logic sel, cnv_lvl, sa_mode, cnv_fall, cnv_rise, sel_rise, long_low;
    logic [1:0] res;
    logic cpu_mode, single_sel;
    logic busy, conv_done, start_req, abort, more, timer_start;
    tcl_pkg::tcl_temp_t meas_d, th_cmp, tl_cmp;
    logic ge_d, le_d;

    // Pins come from the far party: three stages, a change counts when stages 2 and 3 agree
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_s1_q <= `TCL_PIN_RST;
            pin_s2_q <= `TCL_PIN_RST;
            pin_s3_q <= `TCL_PIN_RST;
            pin_lvl_q <= `TCL_PIN_RST;
        end else begin
            pin_s1_q <= {dq_pin_in, shared_clock_convert_pin, bus_enable_pin};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_lvl_q <= (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q ^ pin_s3_q));
        end
    end

    assign sel = pin_lvl_q[`TCL_PIN_SEL];
    assign cnv_lvl = pin_lvl_q[`TCL_PIN_SCLK];
    assign sif.sel = sel;
    assign sif.sclk = cnv_lvl;
    assign sif.dq_in = pin_lvl_q[`TCL_PIN_DQ];

    tcl_serial u_serial (
        .core_clk(core_clk),
        .rst(rst),
        .sif(sif)
    );

    assign res = cfg_nv_q[`TCL_CFG_NV_HI -: 2];
    assign cpu_mode = cfg_nv_q[`TCL_CFG_CPU];
    assign single_sel = cfg_nv_q[`TCL_CFG_SINGLE];

    assign sa_mode = ~cpu_mode & ~sel;
    assign cnv_fall = sa_mode & sclk_prev_q & ~cnv_lvl;
    assign cnv_rise = sa_mode & ~sclk_prev_q & cnv_lvl;
    assign sel_rise = sel & ~sel_prev_q;
    // Counter saturates, so a very long low never wraps back into a short one
    assign long_low = low_cnt_q >= LW'(SHORT_CNV_CYC);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sclk_prev_q <= 1'b1;
            sel_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= cnv_lvl;
            sel_prev_q <= sel;
        end
    end

    // low time decides one or many
    always_ff @(posedge core_clk) begin
        if (rst)
            low_cnt_q <= '0;
        else if (!(sa_mode && !cnv_lvl))
            low_cnt_q <= '0;
        else if (!long_low)
            low_cnt_q <= low_cnt_q + 1'b1;
    end

    assign start_req = sif.start_p | cnv_fall;
    assign abort = sif.stop_p | (sa_owner_q & (sel_rise | (cnv_rise & long_low)));
    assign more = cont_q | (sa_owner_q & sa_mode & ~cnv_lvl & long_low);
    assign timer_start = ~abort & ((state_q == tcl_pkg::TCL_IDLE & start_req) |
                                   (state_q == tcl_pkg::TCL_CONV & conv_done & more));

    tcl_conv_timer #(
        .BASE_CYC(BASE_CONV_CYC),
        .CW(CW)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .start(timer_start),
        .abort(abort),
        .res(res),
        .busy(busy),
        .done(conv_done)
    );

    always_ff @(posedge core_clk) begin
        if (rst)
            state_q <= tcl_pkg::TCL_IDLE;
        else if (abort)
            state_q <= tcl_pkg::TCL_IDLE;
        else
            unique case (state_q)
                tcl_pkg::TCL_IDLE: if (start_req) state_q <= tcl_pkg::TCL_CONV;
                tcl_pkg::TCL_CONV: if (conv_done && !more) state_q <= tcl_pkg::TCL_IDLE;
            endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            cont_q <= 1'b0;
        else if (sif.stop_p)
            cont_q <= 1'b0;
        else if (sif.start_p)
            cont_q <= ~single_sel;
    end

    // Marks a conversion started by the pin, so only the pin or a session may halt it
    always_ff @(posedge core_clk) begin
        if (rst)
            sa_owner_q <= 1'b0;
        else if (sif.start_p || abort)
            sa_owner_q <= 1'b0;
        else if (cnv_fall && state_q == tcl_pkg::TCL_IDLE)
            sa_owner_q <= 1'b1;
        else if (state_q == tcl_pkg::TCL_IDLE)
            sa_owner_q <= 1'b0;
    end

    // Levels stored at a finer resolution are cut again when it coarsens
    // truncate then compare signed
    assign meas_d = tcl_pkg::tcl_trunc(sensor_code, res);
    assign th_cmp = tcl_pkg::tcl_trunc(th_q, res);
    assign tl_cmp = tcl_pkg::tcl_trunc(tl_q, res);
    assign ge_d = $signed(meas_d) >= $signed(th_cmp);
    assign le_d = $signed(meas_d) <= $signed(tl_cmp);

    always_ff @(posedge core_clk) begin
        if (rst)
            meas_q <= 12'h000;
        else if (conv_done)
            meas_q <= meas_d;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            over_q <= 1'b0;
            under_q <= 1'b0;
            hyst_q <= 1'b0;
        end else if (conv_done) begin
            over_q <= ge_d;
            under_q <= le_d;
            if (ge_d)
                hyst_q <= 1'b1;
            else if (le_d)
                hyst_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            th_q <= `TCL_TRIP_RST;
            tl_q <= `TCL_TRIP_RST;
        end else begin
            if (sif.wr_hi_p)
                th_q <= tcl_pkg::tcl_trunc(sif.wdata, res);
            if (sif.wr_lo_p)
                tl_q <= tcl_pkg::tcl_trunc(sif.wdata, res);
        end
    end

    // Nonvolatile bits are held as plain flops reset to factory values
    always_ff @(posedge core_clk) begin
        if (rst)
            cfg_nv_q <= `TCL_CFG_NV_RST;
        else if (sif.wr_cfg_p)
            cfg_nv_q <= sif.wdata[7:4];
    end

    // sticky flags, set wins over clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            over_flag_q <= 1'b0;
            under_flag_q <= 1'b0;
        end else begin
            over_flag_q <= (conv_done & ge_d) |
                           (over_flag_q & ~(sif.wr_cfg_p & ~sif.wdata[4 + `TCL_CFG_OVER]));
            under_flag_q <= (conv_done & le_d) |
                            (under_flag_q & ~(sif.wr_cfg_p & ~sif.wdata[4 + `TCL_CFG_UNDER]));
        end
    end

    assign sif.temp = tcl_pkg::tcl_trunc(meas_q, res);
    assign sif.th = th_cmp;
    assign sif.tl = tl_cmp;
    // No nonvolatile write delay is modelled, so the write busy bit reads zero
    assign sif.cfg = {~busy, over_flag_q, under_flag_q, 1'b0, cfg_nv_q};

    assign dq_pin_out = sif.dq_out;
    assign dq_pin_oe = sif.dq_oe;
    assign over_trip_output = over_q;
    assign under_trip_output = under_q;
    assign hysteresis_output = hyst_q;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    over_out_a: assert property (conv_done |=> over_trip_output == $past(ge_d))
        else $error("over output does not follow compare");
    under_out_a: assert property (conv_done |=> under_trip_output == $past(le_d))
        else $error("under output does not follow compare");
    outputs_hold_a: assert property (!conv_done |=> $stable({over_q, under_q, hyst_q}))
        else $error("thermostat output moved without conversion");
    hyst_set_a: assert property (conv_done && ge_d |=> hysteresis_output)
        else $error("hysteresis output not set");
    hyst_clear_a: assert property (conv_done && le_d && !ge_d |=> !hysteresis_output)
        else $error("hysteresis output not cleared");
    flag_sticky_a: assert property (over_flag_q && !sif.wr_cfg_p |=> over_flag_q)
        else $error("over flag dropped without write");
    flag_set_a: assert property (conv_done && le_d |=> under_flag_q)
        else $error("under flag not set");
    trip_zero_a: assert property ((sif.wr_hi_p && res == 2'h0 |=> th_q[2:0] == 3'h0) and
        (sif.wr_lo_p && res == 2'h0 |=> tl_q[2:0] == 3'h0))
        else $error("unused trip level bits kept");
    one_shot_a: assert property (conv_done && state_q == tcl_pkg::TCL_CONV && !more && !abort
        |=> state_q == tcl_pkg::TCL_IDLE ##1 !busy)
        else $error("one-shot did not return to idle");
    stop_cmd_a: assert property (sif.stop_p |=> state_q == tcl_pkg::TCL_IDLE && !cont_q && !busy)
        else $error("stop command did not halt");
    sa_start_a: assert property (cnv_fall && state_q == tcl_pkg::TCL_IDLE && !sif.start_p
        |=> busy && state_q == tcl_pkg::TCL_CONV)
        else $error("pin fall did not start conversion");
    sa_halt_a: assert property (sa_owner_q && sel_rise |=> !busy)
        else $error("session did not halt stand-alone conversion");
    over_flag_set_a: assert property (conv_done && ge_d |=> over_flag_q)
        else $error("over flag not set");
    meas_low_zero_a: assert property (conv_done && res == 2'h0 |=> meas_q[2:0] == 3'h0)
        else $error("unused measurement bits kept");
    sa_repeat_a: assert property (conv_done && sa_owner_q && sa_mode && !cnv_lvl && long_low |=> busy)
        else $error("stand-alone continuous conversion did not restart");
    single_stop_a: assert property (conv_done && !cont_q && !sa_owner_q |=> !busy)
        else $error("single conversion mode started another conversion");
endmodule : tcl_top

// *** core/tcl_defines.svh ***
`ifndef TCL_DEFINES_SVH
`define TCL_DEFINES_SVH

// Pin vector positions and their levels after reset
`define TCL_PIN_SEL 0
`define TCL_PIN_SCLK 1
`define TCL_PIN_DQ 2
`define TCL_PIN_RST 3'h6

// Serial framing, counted in bits
`define TCL_CMD_BITS 5'h08
`define TCL_TRIP_BITS 5'h0c
`define TCL_CFG_BITS 5'h08
`define TCL_CNT_MAX 5'h1f

// Command codes
`define TCL_CMD_START 8'h51
`define TCL_CMD_STOP 8'h22
`define TCL_CMD_RD_TEMP 8'haa
`define TCL_CMD_WR_HI 8'h01
`define TCL_CMD_WR_LO 8'h02
`define TCL_CMD_RD_HI 8'ha1
`define TCL_CMD_RD_LO 8'ha2
`define TCL_CMD_WR_CFG 8'h0c
`define TCL_CMD_RD_CFG 8'hac

// Configuration byte layout
`define TCL_CFG_DONE 7
`define TCL_CFG_OVER 6
`define TCL_CFG_UNDER 5
`define TCL_CFG_NV_HI 3
`define TCL_CFG_CPU 1
`define TCL_CFG_SINGLE 0
`define TCL_CFG_NV_RST 4'hc
`define TCL_TRIP_RST 12'h000

// Timing
`define TCL_CLK_MHZ 100
`define TCL_TC9_US 93750
`define TCL_CNV_SHORT_US 10000

`endif

// *** core/tcl_pkg.sv ***
package tcl_pkg;

typedef logic [11:0] tcl_temp_t;

typedef enum logic {TCL_IDLE, TCL_CONV} tcl_conv_state_t;

// Clears the low bits that the resolution leaves unused
function automatic tcl_temp_t tcl_trunc(input tcl_temp_t v, input logic [1:0] res);
    return v & ~{9'h000, 3'h7 >> res};
endfunction : tcl_trunc

endpackage : tcl_pkg

// *** core/tcl_ser_if.sv ***
`timescale 1ns/10ps
interface tcl_ser_if;
    logic sclk;
    logic sel;
    logic dq_in;
    logic dq_out;
    logic dq_oe;
    logic start_p;
    logic stop_p;
    logic wr_hi_p;
    logic wr_lo_p;
    logic wr_cfg_p;
    tcl_pkg::tcl_temp_t wdata;
    tcl_pkg::tcl_temp_t temp;
    tcl_pkg::tcl_temp_t th;
    tcl_pkg::tcl_temp_t tl;
    logic [7:0] cfg;
    modport ser(input sclk, sel, dq_in, temp, th, tl, cfg,
                output dq_out, dq_oe, start_p, stop_p, wr_hi_p, wr_lo_p, wr_cfg_p, wdata);
    modport core(output sclk, sel, dq_in, temp, th, tl, cfg,
                 input dq_out, dq_oe, start_p, stop_p, wr_hi_p, wr_lo_p, wr_cfg_p, wdata);
endinterface : tcl_ser_if

// *** core/tcl_serial.sv ***
`timescale 1ns/10ps
`include "tcl_defines.svh"
module tcl_serial (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset
    tcl_ser_if.ser sif // Filtered pins and register access
);
    logic prev_q;
    logic [4:0] cnt_q;
    logic [7:0] cmd_q;
    tcl_pkg::tcl_temp_t data_q;
    tcl_pkg::tcl_temp_t rd_q;
    logic dq_out_q, oe_q, start_q, stop_q, wr_hi_q, wr_lo_q, wr_cfg_q;
    logic rise, fall, rd_cmd;
    logic [7:0] cmd_full;

    assign rise = sif.sel & sif.sclk & ~prev_q;
    assign fall = sif.sel & ~sif.sclk & prev_q;
    assign cmd_full = {sif.dq_in, cmd_q[7:1]};
    assign rd_cmd = (cmd_q == `TCL_CMD_RD_TEMP) | (cmd_q == `TCL_CMD_RD_HI) |
                    (cmd_q == `TCL_CMD_RD_LO) | (cmd_q == `TCL_CMD_RD_CFG);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prev_q <= 1'b1;
            cnt_q <= 5'h00;
            cmd_q <= 8'h00;
            data_q <= 12'h000;
            rd_q <= 12'h000;
            dq_out_q <= 1'b0;
            oe_q <= 1'b0;
            {start_q, stop_q, wr_hi_q, wr_lo_q, wr_cfg_q} <= 5'h00;
        end else begin
            prev_q <= sif.sclk;
            {start_q, stop_q, wr_hi_q, wr_lo_q, wr_cfg_q} <= 5'h00;
            if (!sif.sel) begin
                cnt_q <= 5'h00;
                oe_q <= 1'b0;
            end else if (rise) begin
                oe_q <= 1'b0;
                if (cnt_q != `TCL_CNT_MAX)
                    cnt_q <= cnt_q + 5'h01;
                if (cnt_q < `TCL_CMD_BITS) begin
                    cmd_q <= cmd_full;
                    if (cnt_q == `TCL_CMD_BITS - 5'h01) begin
                        start_q <= cmd_full == `TCL_CMD_START;
                        stop_q <= cmd_full == `TCL_CMD_STOP;
                        unique case (cmd_full)
                            `TCL_CMD_RD_TEMP: rd_q <= sif.temp;
                            `TCL_CMD_RD_HI: rd_q <= sif.th;
                            `TCL_CMD_RD_LO: rd_q <= sif.tl;
                            `TCL_CMD_RD_CFG: rd_q <= {4'h0, sif.cfg};
                            default: rd_q <= 12'h000;
                        endcase
                    end
                end else begin
                    data_q <= {sif.dq_in, data_q[11:1]};
                    if (cnt_q == `TCL_CMD_BITS + `TCL_TRIP_BITS - 5'h01) begin
                        wr_hi_q <= cmd_q == `TCL_CMD_WR_HI;
                        wr_lo_q <= cmd_q == `TCL_CMD_WR_LO;
                    end
                    if (cnt_q == `TCL_CMD_BITS + `TCL_CFG_BITS - 5'h01)
                        wr_cfg_q <= cmd_q == `TCL_CMD_WR_CFG;
                end
            end else if (fall && cnt_q >= `TCL_CMD_BITS && rd_cmd) begin
                dq_out_q <= rd_q[0];
                rd_q <= {1'b0, rd_q[11:1]};
                oe_q <= 1'b1;
            end
        end
    end

    assign sif.dq_out = dq_out_q;
    assign sif.dq_oe = oe_q;
    assign sif.start_p = start_q;
    assign sif.stop_p = stop_q;
    assign sif.wr_hi_p = wr_hi_q;
    assign sif.wr_lo_p = wr_lo_q;
    assign sif.wr_cfg_p = wr_cfg_q;
    assign sif.wdata = data_q;

    trip_commit_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr_hi_q || wr_lo_q) |-> cnt_q == `TCL_CMD_BITS + `TCL_TRIP_BITS)
        else $error("trip write not on twelfth data bit");
endmodule : tcl_serial

// *** core/tcl_conv_timer.sv ***
`timescale 1ns/10ps
module tcl_conv_timer #(
    parameter int unsigned BASE_CYC = 9375000,
    parameter int CW = 27
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic start, // Begin one conversion
    input wire logic abort, // Drop the running conversion
    input wire logic [1:0] res, // Resolution select
    output logic busy, // Conversion running
    output logic done // One-cycle end of conversion
);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            cnt_q <= '0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start) begin
                busy <= 1'b1;
                cnt_q <= CW'((BASE_CYC << res) - 1);
            end else if (busy) begin
                if (cnt_q == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end

    conv_len_a: assert property (@(posedge core_clk) disable iff (rst)
        start && !abort && res == 2'h3 |=> cnt_q == CW'(BASE_CYC * 8 - 1))
        else $error("12-bit conversion not eight base times");
endmodule : tcl_conv_timer

// *** bench/tcl_host_model.sv ***
`timescale 1ns/10ps
module tcl_host_model (
    input wire logic core_clk, // Pacing clock
    input wire logic dq_pin_out, // Device data drive value
    input wire logic dq_pin_oe, // Device data drive enable
    output logic bus_enable_pin, // Session select
    output logic shared_clock_convert_pin, // Serial clock or convert control
    output logic dq_pin_in // Resolved data wire
);
    // Four core cycles per phase give an 80 ns link clock, just above the pin filter
    localparam int PH = 4;
    logic host_d = 1'b1;
    logic host_oe = 1'b0;
    // Pull-up holds the wire high when nobody drives it
    assign dq_pin_in = dq_pin_oe ? dq_pin_out : (host_oe ? host_d : 1'b1);
    initial begin
        bus_enable_pin = 1'b0;
        shared_clock_convert_pin = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic pins(input logic sel, input logic clk);
        bus_enable_pin = sel;
        shared_clock_convert_pin = clk;
    endtask : pins
    task automatic xfer(input logic [7:0] cmd, input int nw, input logic [15:0] wd, input int nr,
                        output logic [15:0] rd);
        logic [23:0] sh;
        sh = {wd, cmd};
        rd = 16'h0000;
        tick(1);
        bus_enable_pin = 1'b1;
        tick(PH);
        for (int i = 0; i < 8 + nw + nr; i++) begin
            shared_clock_convert_pin = 1'b0;
            host_oe = (i < 8 + nw);
            if (i < 8 + nw) begin
                host_d = sh[i];
            end
            tick(PH);
            shared_clock_convert_pin = 1'b1;
            tick(PH);
            // Device answers a few core cycles after the fall and holds until it sees the rise
            if (i >= 8 + nw) begin
                rd[i - 8 - nw] = dq_pin_in;
            end
        end
        host_oe = 1'b0;
        bus_enable_pin = 1'b0;
        tick(PH);
    endtask : xfer
endmodule : tcl_host_model

// *** bench/testbench.sv ***
`timescale 1ns/10ps
`include "tcl_defines.svh"
module testbench;
    localparam int BASE = 100;
    localparam int SHORT = 300;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] sensor_code = 12'h000;
    logic bus_enable_pin, shared_clock_convert_pin, dq_pin_in, dq_pin_out, dq_pin_oe;
    logic over_trip_output, under_trip_output, hysteresis_output;
    logic [15:0] rd;
    int bad_count = 0;
    int check_count = 0;
    int n;
    always #5 core_clk = ~core_clk;
    tcl_top #(.BASE_CONV_CYC(BASE), .SHORT_CNV_CYC(SHORT)) uut (
        .core_clk(core_clk), .rst(rst), .bus_enable_pin(bus_enable_pin),
        .shared_clock_convert_pin(shared_clock_convert_pin), .dq_pin_in(dq_pin_in),
        .dq_pin_out(dq_pin_out), .dq_pin_oe(dq_pin_oe), .sensor_code(sensor_code),
        .over_trip_output(over_trip_output), .under_trip_output(under_trip_output),
        .hysteresis_output(hysteresis_output));
    tcl_host_model host (
        .core_clk(core_clk), .dq_pin_out(dq_pin_out), .dq_pin_oe(dq_pin_oe),
        .bus_enable_pin(bus_enable_pin), .shared_clock_convert_pin(shared_clock_convert_pin),
        .dq_pin_in(dq_pin_in));
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chk_out(input logic [2:0] exp, input string what);
        chk({13'h0000, over_trip_output, under_trip_output, hysteresis_output}, {13'h0000, exp}, what);
    endtask : chk_out
    task automatic wr(input logic [7:0] cmd, input int nw, input logic [15:0] wd);
        host.xfer(cmd, nw, wd, 0, rd);
    endtask : wr
    task automatic rdc(input logic [7:0] cmd, input int nr, input logic [15:0] exp, input string what);
        host.xfer(cmd, 0, 16'h0000, nr, rd);
        chk(rd, exp, what);
    endtask : rdc
    // Margin covers pin filtering and command overhead
    task automatic conv(input int k);
        host.tick(k * ((BASE << 3) + 40));
    endtask : conv
    task automatic meas(input logic [11:0] s, input logic [2:0] exp, input string what);
        sensor_code = s;
        wr(`TCL_CMD_START, 0, 16'h0000);
        conv(1);
        chk_out(exp, what);
    endtask : meas
    initial begin
        // About twice the expected run length
        repeat (50000) @(posedge core_clk);
        bad_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        host.tick(5);
        rst = 1'b0;
        chk_out(3'b000, "reset outputs");
        rdc(`TCL_CMD_RD_CFG, 8, 16'h008c, "reset config");
        rdc(`TCL_CMD_RD_HI, 12, 16'h0000, "reset upper");
        wr(`TCL_CMD_WR_CFG, 8, 16'h000f);
        wr(`TCL_CMD_WR_HI, 16, 16'hf123);
        rdc(`TCL_CMD_RD_HI, 12, 16'h0123, "upper extra bits");
        wr(`TCL_CMD_WR_HI, 8, 16'h0091);
        rdc(`TCL_CMD_RD_HI, 12, 16'h0123, "upper short write");
        wr(`TCL_CMD_WR_HI, 12, 16'h0191);
        wr(`TCL_CMD_WR_LO, 12, 16'h00a2);
        rdc(`TCL_CMD_RD_LO, 12, 16'h00a2, "lower level");
        meas(12'h7d0, 3'b101, "hot");
        rdc(`TCL_CMD_RD_TEMP, 12, 16'h07d0, "temp hot");
        sensor_code = 12'h100;
        conv(2);
        chk_out(3'b101, "single conversion only");
        meas(12'h100, 3'b001, "between levels");
        meas(12'hf5e, 3'b010, "cold signed");
        rdc(`TCL_CMD_RD_TEMP, 12, 16'h0f5e, "temp negative");
        rdc(`TCL_CMD_RD_CFG, 8, 16'h00ef, "flags set");
        wr(`TCL_CMD_WR_CFG, 8, 16'h000f);
        rdc(`TCL_CMD_RD_CFG, 8, 16'h008f, "flags cleared");
        for (int r = 0; r < 4; r++) begin
            wr(`TCL_CMD_WR_CFG, 8, {12'h000, r[1:0], 2'b11});
            wr(`TCL_CMD_WR_LO, 12, 16'h0fff);
            rdc(`TCL_CMD_RD_LO, 12, {4'h0, 12'hfff & ~(12'h007 >> r)}, "lower truncated");
            sensor_code = r[0] ? 12'hf5f : 12'h7d7;
            wr(`TCL_CMD_START, 0, 16'h0000);
            n = 0;
            while (over_trip_output === r[0] && n < 4000) begin
                host.tick(1);
                n++;
            end
            chk(16'(n >= (BASE << r) - 70 && n <= (BASE << r)), 16'h0001, "conversion time");
            rdc(`TCL_CMD_RD_TEMP, 12, {4'h0, sensor_code & ~(12'h007 >> r)}, "temp truncated");
        end
        wr(`TCL_CMD_WR_LO, 12, 16'h00a2);
        wr(`TCL_CMD_WR_CFG, 8, 16'h000e);
        sensor_code = 12'h191;
        wr(`TCL_CMD_START, 0, 16'h0000);
        conv(1);
        chk_out(3'b101, "at upper level");
        sensor_code = 12'h0a2;
        conv(2);
        chk_out(3'b010, "continuous at lower");
        wr(`TCL_CMD_STOP, 0, 16'h0000);
        sensor_code = 12'h7d0;
        conv(2);
        chk_out(3'b010, "stopped");
        host.pins(1'b0, 1'b0);
        conv(1);
        chk_out(3'b010, "pin ignored in host mode");
        host.pins(1'b0, 1'b1);
        wr(`TCL_CMD_WR_CFG, 8, 16'h000d);
        host.pins(1'b0, 1'b0);
        host.tick(50);
        host.pins(1'b0, 1'b1);
        conv(1);
        chk_out(3'b101, "short pulse");
        sensor_code = 12'hf5e;
        conv(2);
        chk_out(3'b101, "short pulse once");
        host.pins(1'b0, 1'b0);
        conv(1);
        chk_out(3'b010, "long low");
        sensor_code = 12'h7d0;
        conv(1);
        chk_out(3'b101, "continuous ignores single bit");
        host.pins(1'b0, 1'b1);
        sensor_code = 12'hf5e;
        conv(2);
        chk_out(3'b101, "pin release stops");
        host.pins(1'b0, 1'b0);
        conv(1);
        chk_out(3'b010, "long low again");
        host.pins(1'b1, 1'b0);
        sensor_code = 12'h7d0;
        conv(2);
        chk_out(3'b010, "session halts");
        host.pins(1'b1, 1'b1);
        host.tick(10);
        host.pins(1'b0, 1'b1);
        end_of_test();
    end
endmodule : testbench
